// *** ext_clk_src.sv ***
// Purpose: Far-side source of count pulses on the external count clock pin.
// Assumes: Bench asks for a burst with a one-cycle start; idle pin rests low.
// Notes:   Pulses are 4 high then 4 low, above the 6-cycle minimum spacing.
`timescale 1ns/10ps
module ext_clk_src (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Burst request
  input wire logic start,
  input wire logic [7:0] n_pulses,
  // Pin and status
  output logic pin,
  output logic busy
);
  logic [7:0] left_r;
  logic [2:0] ph_r;
  // Burst counter; the clock stands still between bursts
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      left_r <= 8'h00;
      ph_r <= 3'h0;
    end else if (start && left_r == 8'h00) begin
      left_r <= n_pulses;
      ph_r <= 3'h0;
    end else if (left_r != 8'h00) begin
      ph_r <= ph_r + 3'h1;
      if (ph_r == 3'h7) begin
        left_r <= left_r - 8'h01;
      end
    end
  end
  assign pin = (left_r != 8'h00) && !ph_r[2];
  assign busy = (left_r != 8'h00);
endmodule // ext_clk_src

// *** pin_sampler.sv ***
// Purpose: Three-stage sampler for pins from outside the mclk domain.
// Assumes: Pins may change at any time; glitches shorter than a cycle are lost.
// Notes:   The level moves only when stages two and three agree.
`timescale 1ns/10ps
module pin_sampler (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Raw pins
  input wire logic [tmr_interval_pkg::PIN_N-1:0] pin_raw,
  // Filtered levels
  output logic [tmr_interval_pkg::PIN_N-1:0] pin_lvl
);
  import tmr_interval_pkg::*;

  logic [PIN_N-1:0] s1_r;
  logic [PIN_N-1:0] s2_r;
  logic [PIN_N-1:0] s3_r;
  logic [PIN_N-1:0] lvl_r;
  logic [PIN_N-1:0] lvl_nxt;

  // ********************************************************
  // Per-pin agreement filter
  // ********************************************************
  genvar g;
  generate
    for (g = 0; g < PIN_N; g++) begin : g_pin
      // Stage one feeds only stage two, so metastability cannot leak
      always_comb begin
        lvl_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : lvl_r[g];
      end
    end
  endgenerate

  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_r <= PIN_RST;
      s2_r <= PIN_RST;
      s3_r <= PIN_RST;
      lvl_r <= PIN_RST;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign pin_lvl = lvl_r;

endmodule // pin_sampler

// *** timer1_interval_counter.sv ***
// Purpose: 16-bit free-running interval timer/counter with four modes.
// Assumes: mclk is the instruction cycle clock; pins are asynchronous to it.
// Notes:   Control, prescale ratio and period are plain inputs, no bus.
//
// Overview of operation
// - The counter is 16 bits wide, free running, and counts timer ticks or external events.
// - In timer and gated timer modes the count source is the instruction cycle clock.
// - In both counter modes the count source is the external count clock pin.
// - Asynchronous counter mode advances straight from the prescaled pin edges.
// - Synchronous counter mode aligns the count to the clock after the prescaler.
// - The clock source select bit sits at bit 1 of the control word.
// - The external sync select bit sits at bit 2 of the control word.
// - The gate accumulate enable bit sits at bit 6 of the control word.
// - Source 0 gives timer or gated timer by gate; source 1 gives sync or async by sync.
`timescale 1ns/10ps
module timer1_interval_counter (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Configuration
  input wire tmr_interval_pkg::interval_timer_control_s interval_timer_control,
  input wire logic [1:0] prescale_sel,
  input wire logic [tmr_interval_pkg::COUNT_W-1:0] period,
  input wire logic flag_clear,
  // Pins
  input wire logic ext_count_clock_pin,
  input wire logic gate_pin,
  // Status
  output logic [tmr_interval_pkg::COUNT_W-1:0] count,
  output logic period_flag
);
  import tmr_interval_pkg::*;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_lvl;
  logic ext_lvl;
  logic gate_lvl;
  logic ext_prev_r;
  logic ext_edge;
  timer_mode_e mode;
  logic src_tick;
  logic [PRE_W-1:0] pre_last;
  logic [PRE_W-1:0] pre_cnt_r;
  logic [PRE_W-1:0] pre_cnt_nxt;
  logic pre_tick;
  logic sync_tick_r;
  logic tick;
  logic match;
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic period_flag_r;
  logic period_flag_nxt;

  // ********************************************************
  // Pin sampling
  // ********************************************************
  // Both pins share one sampler, the count pin in bit zero
  assign pin_raw = {gate_pin, ext_count_clock_pin};

  // Pins reach the logic four cycles late; pulses under two cycles may be lost
  pin_sampler u_pins (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_raw(pin_raw),
    .pin_lvl(pin_lvl)
  );

  // Filtered levels and the rising-edge detect on the count pin
  assign ext_lvl = pin_lvl[PIN_COUNT];
  assign gate_lvl = pin_lvl[PIN_GATE];
  assign ext_edge = ext_lvl & ~ext_prev_r;  // Rising edge counts one event

  // ********************************************************
  // Mode decode
  // ********************************************************
  // Bit positions come from the packed control layout
  // Mode follows the control word at once; prescaler phase is kept across a change
  always_comb begin
    if (!interval_timer_control.clock_source_select) begin
      mode = interval_timer_control.gate_accumulate_enable ? MODE_GATED : MODE_TIMER;
    end else begin
      mode = interval_timer_control.external_sync_select ? MODE_SYNC_CNT : MODE_ASYNC_CNT;
    end
  end

  // Count source ahead of the prescaler
  always_comb begin
    case (mode)
      MODE_TIMER: src_tick = 1'b1;
      MODE_GATED: src_tick = gate_lvl;
      MODE_SYNC_CNT: src_tick = ext_edge;
      MODE_ASYNC_CNT: src_tick = ext_edge;
      default: src_tick = 1'b0;
    endcase
  end

  // ********************************************************
  // Prescaler
  // ********************************************************
  // Ratio select: 1, 8, 64 or 256
  always_comb begin
    case (prescale_sel)
      2'h0: pre_last = PRE_LAST_1;
      2'h1: pre_last = PRE_LAST_8;
      2'h2: pre_last = PRE_LAST_64;
      2'h3: pre_last = PRE_LAST_256;
      default: pre_last = PRE_LAST_1;
    endcase
  end

  // A ratio change mid-run may give one short or long period; no holdoff is kept
  always_comb begin
    pre_tick = src_tick && (pre_cnt_r >= pre_last);
    pre_cnt_nxt = pre_cnt_r;
    if (src_tick) begin
      pre_cnt_nxt = pre_tick ? PRE_RST : pre_cnt_r + 8'h01;
    end
  end

  // ********************************************************
  // Counter and period match
  // ********************************************************
  // Sync mode takes the prescaled tick one cycle late, aligned to the clock
  always_comb begin
    tick = (mode == MODE_SYNC_CNT) ? sync_tick_r : pre_tick;
    match = tick && (count_r == period);
    count_nxt = count_r;
    if (match) begin
      count_nxt = COUNT_RST;
    end else if (tick) begin
      count_nxt = count_r + 16'h0001;
    end
    // A new match beats a clear in the same cycle
    period_flag_nxt = (period_flag_r & ~flag_clear) | match;
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext_prev_r <= 1'b0;
      pre_cnt_r <= PRE_RST;
      sync_tick_r <= 1'b0;
      count_r <= COUNT_RST;
      period_flag_r <= 1'b0;
    end else begin
      ext_prev_r <= ext_lvl;
      pre_cnt_r <= pre_cnt_nxt;
      sync_tick_r <= pre_tick && (mode == MODE_SYNC_CNT);
      count_r <= count_nxt;
      period_flag_r <= period_flag_nxt;
    end
  end

  // Outputs straight from registers
  assign count = count_r;
  assign period_flag = period_flag_r;

  // ********************************************************
  // Checks
  // ********************************************************
  // Counter stepping, source and mode decode
  free_run_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tick && count_r != period) |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not step by one");
  timer_every_cycle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_TIMER && prescale_sel == 2'h0 && count_r != period)
    |=> count_r == $past(count_r) + 16'h0001)
    else $error("timer mode missed an instruction cycle");
  pin_source_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (interval_timer_control[CTRL_SRC_BIT] && !ext_edge) |-> !pre_tick)
    else $error("counter mode ticked without a pin edge");
  async_direct_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_ASYNC_CNT && pre_tick && count_r != period)
    |=> count_r == $past(count_r) + 16'h0001)
    else $error("async count did not follow prescaler at once");
  sync_after_pre_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_SYNC_CNT && pre_tick && count_r != period) ##1
    (mode == MODE_SYNC_CNT && count_r != period) |=> count_r == $past(count_r, 2) + 16'h0001)
    else $error("sync count not one cycle after prescaler");
  mode_decode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode == (interval_timer_control[CTRL_SRC_BIT]
      ? (interval_timer_control[CTRL_SYNC_BIT] ? MODE_SYNC_CNT : MODE_ASYNC_CNT)
      : (interval_timer_control[CTRL_GATE_BIT] ? MODE_GATED : MODE_TIMER)))
    else $error("mode decode wrong");
  gate_low_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_GATED && !gate_lvl) |=> $stable(count_r) && $stable(pre_cnt_r))
    else $error("gated timer counted with gate low");
  period_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tick && count_r == period) |=> count_r == COUNT_RST && period_flag_r)
    else $error("period match did not wrap and flag");
  flag_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (period_flag_r && !flag_clear) |=> period_flag_r)
    else $error("flag dropped without clear");

  // Flag clears only in a cycle with no match
  flag_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (flag_clear && !match) |=> !period_flag_r)
    else $error("flag not cleared by clear");

  // Outputs leave reset at their reset values; the count holds without a tick
  reset_state_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> (count_r == COUNT_RST && !period_flag_r))
    else $error("outputs not at reset values");
  count_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !tick |=> $stable(count_r))
    else $error("counter moved without a tick");

  // Prescaler steps on every instruction cycle in timer mode and wraps on its tick
  timer_src_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_TIMER) |-> src_tick)
    else $error("timer mode lost its cycle source");
  pre_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_TIMER && !pre_tick) |=> pre_cnt_r == $past(pre_cnt_r) + 8'h01)
    else $error("prescaler missed an instruction cycle");
  pre_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pre_tick |=> pre_cnt_r == PRE_RST)
    else $error("prescaler did not wrap on its tick");

  // Sync mode never counts without the alignment stage
  sync_stage_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (mode == MODE_SYNC_CNT && !sync_tick_r) |=> $stable(count_r))
    else $error("sync count bypassed the alignment stage");

endmodule // timer1_interval_counter

// *** timer1_interval_counter_tb_top.sv ***
// Purpose: Self-checking bench for the interval timer/counter.
// Assumes: Inputs change by non-blocking assignment on the rising edge.
// Notes:   Each scenario restarts from reset so prescaler phase is known.
`timescale 1ns/10ps
module timer1_interval_counter_tb_top;
  import tmr_interval_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  interval_timer_control_s ctrl = '0;
  logic [1:0] pre = 2'h0;
  logic [15:0] per = 16'hffff;
  logic flag_clear = 1'b0;
  logic gate_pin = 1'b0;
  logic start = 1'b0;
  logic [7:0] n_pulses = 8'h00;
  logic ext_pin;
  logic busy;
  logic [15:0] count;
  logic period_flag;
  logic [15:0] c0;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int k;
  int ratio[4] = '{1, 8, 64, 256};

  always #2.5 mclk = ~mclk;

  timer1_interval_counter dut (.mclk(mclk), .rst_n(rst_n), .interval_timer_control(ctrl),
    .prescale_sel(pre), .period(per), .flag_clear(flag_clear), .ext_count_clock_pin(ext_pin),
    .gate_pin(gate_pin), .count(count), .period_flag(period_flag));
  ext_clk_src src (.mclk(mclk), .rst_n(rst_n), .start(start), .n_pulses(n_pulses),
    .pin(ext_pin), .busy(busy));

  // ********************************************************
  // Helpers
  // ********************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait n edges, then look once the outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Stop on an edge so the next drive is a non-blocking assignment there
  task automatic to_edge(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Control word built from raw bit positions, not struct fields
  task automatic restart(input logic s, input logic y, input logic g, input logic [1:0] p,
    input logic [15:0] pv);
    logic [15:0] v;
    v = 16'h0000;
    v[1] = s;
    v[2] = y;
    v[6] = g;
    to_edge(1);
    rst_n <= 1'b0;
    ctrl <= interval_timer_control_s'(v);
    pre <= p;
    per <= pv;
    to_edge(4);
    rst_n <= 1'b1;
    tick(0);
    check(count, 16'h0000);
    check({15'h0, period_flag}, 16'h0000);
  endtask

  task automatic send_pulses(input logic [7:0] n);
    @(posedge mclk);
    start <= 1'b1;
    n_pulses <= n;
    @(posedge mclk);
    start <= 1'b0;
    tick(0);
  endtask

  // ********************************************************
  // Scenarios
  // ********************************************************
  // Timer walk with sync bit set, which the timer mode ignores
  task automatic timer_walk;
    restart(1'b0, 1'b1, 1'b0, 2'h0, 16'h0002);
    tick(1);
    check(count, 16'h0001);
    tick(1);
    check(count, 16'h0002);
    tick(1);
    check(count, 16'h0000);
    check({15'h0, period_flag}, 16'h0001);
    // Clear held over a match cycle and the one after: the set wins first
    to_edge(2);
    flag_clear <= 1'b1;
    tick(1);
    check({15'h0, period_flag}, 16'h0001);
    tick(1);
    check({15'h0, period_flag}, 16'h0000);
    check(count, 16'h0001);
    to_edge(1);
    flag_clear <= 1'b0;
    tick(0);
    check({15'h0, period_flag}, 16'h0000);
  endtask

  task automatic prescale_ratios;
    for (int i = 0; i < 4; i++) begin
      restart(1'b0, 1'b0, 1'b0, 2'(i), 16'hffff);
      tick(ratio[i] - 1);
      check(count, 16'h0000);
      tick(1);
      check(count, 16'h0001);
    end
  endtask

  task automatic gated;
    restart(1'b0, 1'b0, 1'b1, 2'h0, 16'hffff);
    tick(20);
    check(count, 16'h0000);
    to_edge(1);
    gate_pin <= 1'b1;
    tick(10);
    c0 = count;
    tick(16);
    check(count - c0, 16'h0010);
    to_edge(1);
    gate_pin <= 1'b0;
    tick(10);
    c0 = count;
    tick(16);
    check(count, c0);
  endtask

  // Gate bit set with gate low: counter modes must ignore it
  task automatic pin_latency(input logic y, input int exp);
    restart(1'b1, y, 1'b1, 2'h0, 16'hffff);
    send_pulses(8'h01);
    k = 0;
    while (count === 16'h0000 && k < 20) begin
      tick(1);
      k++;
    end
    check(16'(k), 16'(exp));
  endtask

  task automatic pin_count;
    restart(1'b1, 1'b1, 1'b0, 2'h1, 16'hffff);
    send_pulses(8'h10);
    k = 0;
    while (busy === 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
    tick(10);
    check(count, 16'h0002);
  endtask

  // ********************************************************
  // Run control
  // ********************************************************
  task automatic final_report;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard well beyond the six hundred or so cycles the scenarios take
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    // Fifteen edges here and five in the first restart hold reset for twenty
    to_edge(15);
    timer_walk();
    prescale_ratios();
    gated();
    pin_latency(1'b0, 5);
    pin_latency(1'b1, 6);
    pin_count();
    final_report();
  end
endmodule // timer1_interval_counter_tb_top

// *** tmr_interval_pkg.sv ***
// Purpose: Shared constants and types for the interval timer/counter.
// Assumes: One clock, mclk at 200 MHz; every mclk edge is one instruction cycle.
// Notes:   Bit positions of the control word and prescale ratios live here.
package tmr_interval_pkg;

  // ********************************************************
  // Widths and bit positions
  // ********************************************************
  localparam int COUNT_W = 16;
  localparam int PRE_W = 8;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_SYNC_BIT = 2;
  localparam int CTRL_GATE_BIT = 6;
  localparam int PIN_N = 2;
  localparam int PIN_COUNT = 0;
  localparam int PIN_GATE = 1;

  // ********************************************************
  // Reset values and prescaler terminal counts (ratio minus one)
  // ********************************************************
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [PRE_W-1:0] PRE_RST = 8'h00;
  localparam logic [PRE_W-1:0] PRE_LAST_1 = 8'h00;
  localparam logic [PRE_W-1:0] PRE_LAST_8 = 8'h07;
  localparam logic [PRE_W-1:0] PRE_LAST_64 = 8'h3f;
  localparam logic [PRE_W-1:0] PRE_LAST_256 = 8'hff;
  localparam logic [PIN_N-1:0] PIN_RST = 2'h0;

  // ********************************************************
  // Types
  // ********************************************************
  typedef struct packed {
    logic [8:0] rsvd_hi;
    logic gate_accumulate_enable;
    logic [2:0] rsvd_mid;
    logic external_sync_select;
    logic clock_source_select;
    logic rsvd_lo;
  } interval_timer_control_s;

  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_GATED,
    MODE_SYNC_CNT,
    MODE_ASYNC_CNT
  } timer_mode_e;

endpackage
